// ---- sgs_selector.sv ----
// setting group selector: priority selection of the active parameter group
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "sgs_map.svh"
module sgs_selector #(
	parameter int NGRP = `SGS_NGRP
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NGRP-1:0] req_pin,
	input wire logic [`SGS_AW-1:0] reg_addr,
	input wire logic [`SGS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`SGS_DW-1:0] reg_rdata,
	output logic [NGRP-1:0] active_group,
	output logic [2:0] active_code,
	output logic [NGRP-1:0] group_enabled,
	output logic [NGRP-1:0] group_load_default,
	output logic req_refused
);
	// the code field, the status layout and the used-groups field are all sized for eight groups
	if (NGRP != 8)
	begin : g_check
		$error("sgs_selector serves exactly eight groups");
	end

	sgs_cfg_if cfg ();
	logic [NGRP-1:0] req_lvl;
	logic [NGRP-1:0] req_rise;

	sgs_req_sync #(
		.N(NGRP)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.req_pin(req_pin),
		.req_lvl(req_lvl),
		.req_rise(req_rise)
	);

	sgs_regs u_regs (
		.clk(clk),
		.rst(rst),
		.addr(reg_addr),
		.wdata(reg_wdata),
		.wr(reg_wr),
		.rd(reg_rd),
		.rdata(reg_rdata),
		.cfg(cfg)
	);

	// decode a none/one..eight selection code to a one-hot group vector
	function automatic sgs_pkg::sgs_grp_t sel_onehot(input sgs_pkg::sgs_sel_t sel);
		sgs_pkg::sgs_grp_t v;
		v = '0;
		for (int i = 0; i < 8; i++)
			v[i] = sel == 4'(i + 1);
		return v;
	endfunction

	// one-hot group vector to its three-bit code, group one reads zero
	function automatic logic [2:0] grp_code(input sgs_pkg::sgs_grp_t g);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 8; i++)
			if (g[i])
				c = 3'(i);
		return c;
	endfunction

	// lowest set bit, which is the highest priority group
	function automatic sgs_pkg::sgs_grp_t first_req(input sgs_pkg::sgs_grp_t v);
		return v & (~v + 8'h01);
	endfunction

	sgs_pkg::sgs_grp_t active_ff;
	sgs_pkg::sgs_grp_t nxt_active;
	sgs_pkg::sgs_grp_t en_ff;
	sgs_pkg::sgs_grp_t load_ff;
	logic [2:0] code_ff;
	logic refused_ff;
	sgs_pkg::sgs_mode_e mode_ff;

	// enabled groups follow the used-groups count
	sgs_pkg::sgs_grp_t en_mask;
	genvar gi;
	for (gi = 0; gi < NGRP; gi++)
	begin : g_en
		assign en_mask[gi] = 4'(gi) < cfg.used_cnt;
	end

	// a held level blocks every group of lower priority; group eight has none below it
	sgs_pkg::sgs_grp_t lvl_en;
	sgs_pkg::sgs_grp_t blk;
	assign lvl_en = req_lvl & en_mask;
	assign blk[0] = 1'b0;
	for (gi = 1; gi < NGRP; gi++)
	begin : g_blk
		assign blk[gi] = |lvl_en[gi-1:0];
	end

	// automatic candidates: a fresh pulse edge or a held level of an enabled, unblocked group
	sgs_pkg::sgs_grp_t auto_cand;
	sgs_pkg::sgs_grp_t auto_pick;
	wire auto_any;
	assign auto_cand = (req_rise | req_lvl) & en_mask & ~blk;
	assign auto_pick = first_req(auto_cand);
	assign auto_any = |auto_cand;

	// operator requests
	sgs_pkg::sgs_grp_t frc_oh;
	sgs_pkg::sgs_grp_t rem_oh;
	wire frc_ok;
	wire rem_ok;
	wire frc_bad;
	wire rem_bad;
	assign frc_oh = sel_onehot(cfg.force_sel);
	assign rem_oh = sel_onehot(cfg.remote_sel);
	// forcing needs the force enable and an enabled target group
	assign frc_ok = cfg.force_en && cfg.force_wr && |(frc_oh & en_mask);
	// a remote change also needs the force enable and no held higher group
	assign rem_ok = cfg.force_en && cfg.remote_wr && |(rem_oh & en_mask & ~blk);
	assign frc_bad = cfg.force_wr && !frc_ok;
	assign rem_bad = cfg.remote_wr && !rem_ok;

	// keep the current group, falling back to group one if it lost its enable
	sgs_pkg::sgs_grp_t keep_grp;
	assign keep_grp = |(active_ff & en_mask) ? active_ff : `SGS_RST_GRP;

	sgs_pkg::sgs_mode_e nxt_mode;
	assign nxt_mode = cfg.used_cnt == 4'h1 ? sgs_pkg::SGS_MODE_IDLE :
		cfg.force_en ? sgs_pkg::SGS_MODE_FORCE : sgs_pkg::SGS_MODE_AUTO;

	always_comb
	begin
		nxt_active = keep_grp;
		unique case (nxt_mode)
			sgs_pkg::SGS_MODE_IDLE:
			begin
				nxt_active = `SGS_RST_GRP;
			end
			sgs_pkg::SGS_MODE_FORCE:
			begin
				// automatic inputs are ignored; the forced group persists like a pulse
				if (frc_ok)
					nxt_active = frc_oh;
				else if (rem_ok)
					nxt_active = rem_oh;
			end
			sgs_pkg::SGS_MODE_AUTO:
			begin
				// with no request the last pulse-selected group remains
				if (auto_any)
					nxt_active = auto_pick;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			active_ff <= `SGS_RST_GRP;
			code_ff <= `SGS_RST_CODE;
			en_ff <= `SGS_RST_GRP;
			load_ff <= '0;
			refused_ff <= 1'b0;
			mode_ff <= sgs_pkg::SGS_MODE_IDLE;
		end
		else
		begin
			active_ff <= nxt_active;
			code_ff <= grp_code(nxt_active);
			en_ff <= en_mask;
			load_ff <= en_mask & ~en_ff;
			refused_ff <= frc_bad || rem_bad;
			mode_ff <= nxt_mode;
		end
	end

	assign cfg.active_code = code_ff;
	assign active_group = active_ff;
	assign active_code = code_ff;
	assign group_enabled = en_ff;
	assign group_load_default = load_ff;
	assign req_refused = refused_ff;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_idle_cfg;
		cfg.used_cnt == 4'h1;
	endsequence

	sequence s_quiet_auto;
		mode_ff == sgs_pkg::SGS_MODE_AUTO && nxt_mode == sgs_pkg::SGS_MODE_AUTO && !auto_any;
	endsequence

	sequence s_force_release;
		$fell(cfg.force_en) && cfg.used_cnt > 4'h1 && auto_any;
	endsequence

	property p_onehot;
		$onehot(active_ff) && active_code == grp_code(active_ff);
	endproperty
	a_onehot: assert property (p_onehot) else $error("active group not one-hot or code mismatch");

	property p_idle;
		s_idle_cfg |=> active_ff == 8'h01 && code_ff == 3'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("single group config did not select group one");

	property p_force_ignore;
		cfg.force_en && cfg.used_cnt > 4'h1 && !frc_ok && !rem_ok && |(active_ff & en_mask)
			|=> $stable(active_ff);
	endproperty
	a_force_ignore: assert property (p_force_ignore) else $error("automatic request changed group under force");

	property p_prio;
		nxt_mode == sgs_pkg::SGS_MODE_AUTO && auto_any |=> active_ff == $past(auto_pick);
	endproperty
	a_prio: assert property (p_prio) else $error("not the highest priority request");

	property p_pulse_hold;
		s_quiet_auto ##0 |(active_ff & en_mask) |=> $stable(active_ff);
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("group changed without a request");

	property p_release;
		s_force_release |=> active_ff == $past(auto_pick);
	endproperty
	a_release: assert property (p_release) else $error("levels not followed after force release");

	property p_force_take;
		frc_ok && cfg.used_cnt > 4'h1 |=> active_ff == $past(frc_oh) && code_ff == $past(grp_code(frc_oh));
	endproperty
	a_force_take: assert property (p_force_take) else $error("valid force did not take effect");

	property p_force_gate;
		cfg.force_wr && !cfg.force_en |=> req_refused;
	endproperty
	a_force_gate: assert property (p_force_gate) else $error("force accepted without force enable");

	property p_load;
		cfg.used_cnt != $past(cfg.used_cnt) |=> group_load_default == (en_ff & ~$past(en_ff));
	endproperty
	a_load: assert property (p_load) else $error("newly enabled groups not flagged");

	property p_remote_refuse;
		cfg.remote_wr && |(rem_oh & blk) && !frc_ok |=> req_refused && $stable(active_ff) [*1];
	endproperty
	a_remote_refuse: assert property (p_remote_refuse) else $error("remote request beat a held group");

	property p_g1_static;
		lvl_en[0] && cfg.used_cnt > 4'h1 && !cfg.force_en |=> active_ff == 8'h01;
	endproperty
	a_g1_static: assert property (p_g1_static) else $error("group one level did not block others");

	property p_mid_static;
		nxt_mode == sgs_pkg::SGS_MODE_AUTO && |lvl_en[6:1] |=>
			(active_ff & ~($past(first_req(lvl_en)) | ($past(first_req(lvl_en)) - 8'h01))) == 8'h00;
	endproperty
	a_mid_static: assert property (p_mid_static) else $error("lower group won over a held level");

	property p_g8_static;
		nxt_mode == sgs_pkg::SGS_MODE_AUTO && lvl_en[7] && |(req_rise[6:0] & en_mask[6:0])
			|=> !active_ff[7];
	endproperty
	a_g8_static: assert property (p_g8_static) else $error("group eight level blocked a request");

	property p_pin_path;
		nxt_mode == sgs_pkg::SGS_MODE_AUTO && req_rise[0] |=> active_ff == 8'h01;
	endproperty
	a_pin_path: assert property (p_pin_path) else $error("pulse edge on group one ignored");

	property p_in_range;
		1'b1 |=> (active_ff & ~$past(en_mask)) == 8'h00;
	endproperty
	a_in_range: assert property (p_in_range) else $error("active group beyond used count");

	sequence s_force_off;
		$fell(cfg.force_en) && cfg.used_cnt > 4'h1;
	endsequence

	sequence s_status_read;
		$past(reg_rd) && $past(reg_addr) == `SGS_OFS_STATUS;
	endsequence

	property p_force_refuse;
		cfg.force_wr && cfg.force_en && cfg.used_cnt > 4'h1 && !rem_ok && !(|(frc_oh & en_mask))
			&& |(active_ff & en_mask)
			|=> req_refused && $stable(active_ff);
	endproperty
	a_force_refuse: assert property (p_force_refuse) else $error("force to a disabled group took effect");

	property p_refuse_cause;
		!cfg.force_wr && !cfg.remote_wr |=> !req_refused;
	endproperty
	a_refuse_cause: assert property (p_refuse_cause) else $error("refusal flagged without a request");

	property p_remote_take;
		rem_ok && !cfg.force_wr && cfg.used_cnt > 4'h1 |=> active_ff == $past(rem_oh) && !req_refused;
	endproperty
	a_remote_take: assert property (p_remote_take) else $error("valid remote request did not take effect");

	property p_remote_gate;
		cfg.remote_wr && !cfg.force_en |=> req_refused;
	endproperty
	a_remote_gate: assert property (p_remote_gate) else $error("remote change accepted without force enable");

	property p_load_sub;
		(group_load_default & ~group_enabled) == 8'h00;
	endproperty
	a_load_sub: assert property (p_load_sub) else $error("defaults loaded for a group not enabled");

	property p_en_follow;
		1'b1 |=> group_enabled == 8'((9'h001 << $past(cfg.used_cnt)) - 9'h001);
	endproperty
	a_en_follow: assert property (p_en_follow) else $error("enabled groups differ from used count");

	property p_fallback;
		!(|(active_ff & en_mask)) && !auto_any && !frc_ok && !rem_ok |=> active_ff == 8'h01;
	endproperty
	a_fallback: assert property (p_fallback) else $error("disabled active group did not fall back");

	property p_force_keep;
		s_force_off ##0 !auto_any && |(active_ff & en_mask) |=> $stable(active_ff);
	endproperty
	a_force_keep: assert property (p_force_keep) else $error("forced group lost after force release");

	property p_rise_once;
		(|req_rise) |=> (req_rise & $past(req_rise)) == 8'h00;
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("one pulse gave two selection events");

	property p_status_read;
		s_status_read |-> reg_rdata == {$past(cfg.force_en), 4'h0, $past(code_ff)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read does not show active group");

	property p_rdata_quiet;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data shown without a read");

endmodule // sgs_selector
`default_nettype wire

// ---- sgs_map.svh ----
// offsets, field positions, reset values and sizes of the setting group selector
// What this block does
// - up to eight groups, exactly one active
// - after reset group one only, logic idle
// - two or more enabled: inputs decide group
// - each group has its own request input
// - force enable overrides all automatic requests
// - requests may be pulses or static levels
// - simultaneous requests: highest priority group wins
// - priority falls with group number
// - pulse-selected group stays until another request
// - force release returns control to levels immediately
// - read-only active group code, group one after reset
// - forced group none or one..eight, pulse-like
// - force enable defaults off, needed for changes
// - used-groups count enables groups, new get defaults
// - remote request refused under higher held group
// - static group one level blocks every other
// - static level two..seven blocks lower groups
// - static group eight level blocks nothing
`ifndef SGS_MAP_SVH
`define SGS_MAP_SVH
`define SGS_NGRP 8
`define SGS_AW 4
`define SGS_DW 8
`define SGS_OFS_CTRL 4'h0
`define SGS_OFS_FORCE 4'h4
`define SGS_OFS_REMOTE 4'h8
`define SGS_OFS_STATUS 4'hc
`define SGS_CTRL_FORCE_BIT 0
`define SGS_CTRL_USED_LSB 4
`define SGS_CTRL_USED_MSB 6
`define SGS_SEL_MSB 3
`define SGS_STAT_FORCE_BIT 7
`define SGS_SEL_NONE 4'h0
`define SGS_RST_CTRL 8'h00
`define SGS_RST_GRP 8'h01
`define SGS_RST_CODE 3'h0
`endif

// ---- sgs_pkg.sv ----
// types shared by the setting group selector modules
`default_nettype none
package sgs_pkg;
	typedef logic [7:0] sgs_grp_t;
	typedef logic [3:0] sgs_sel_t;
	typedef enum logic [2:0] {
		SGS_MODE_IDLE = 3'b001,
		SGS_MODE_AUTO = 3'b010,
		SGS_MODE_FORCE = 3'b100
	} sgs_mode_e;
endpackage
`default_nettype wire

// ---- sgs_cfg_if.sv ----
// settings and status passed between register file and selection core
`timescale 1ns/1ns
`default_nettype none
interface sgs_cfg_if;
	logic force_en;
	logic force_wr;
	logic remote_wr;
	sgs_pkg::sgs_sel_t force_sel;
	sgs_pkg::sgs_sel_t remote_sel;
	logic [3:0] used_cnt;
	logic [2:0] active_code;
	modport regs (output force_en, force_wr, remote_wr, force_sel, remote_sel, used_cnt, input active_code);
	modport core (input force_en, force_wr, remote_wr, force_sel, remote_sel, used_cnt, output active_code);
endinterface
`default_nettype wire

// ---- sgs_req_sync.sv ----
// request input synchroniser with rising edge detection
`timescale 1ns/1ns
`default_nettype none
module sgs_req_sync #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] req_pin,
	output logic [N-1:0] req_lvl,
	output logic [N-1:0] req_rise
);
	logic [N-1:0] meta_ff;
	logic [N-1:0] sync_ff;
	logic [N-1:0] prev_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			meta_ff <= req_pin;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end
	// a held level and a short pulse both show as level; the edge marks one event per pulse
	assign req_lvl = sync_ff;
	assign req_rise = sync_ff & ~prev_ff;
endmodule // sgs_req_sync
`default_nettype wire

// ---- sgs_regs.sv ----
// register file of the setting group selector
`timescale 1ns/1ns
`default_nettype none
`include "sgs_map.svh"
module sgs_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`SGS_AW-1:0] addr,
	input wire logic [`SGS_DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [`SGS_DW-1:0] rdata,
	sgs_cfg_if.regs cfg
);
	logic [`SGS_DW-1:0] ctrl_ff;
	sgs_pkg::sgs_sel_t force_ff;
	sgs_pkg::sgs_sel_t remote_ff;
	logic force_wr_ff;
	logic remote_wr_ff;
	logic [`SGS_DW-1:0] rdata_ff;
	logic [`SGS_DW-1:0] nxt_rdata;
	wire hit_ctrl = addr == `SGS_OFS_CTRL;
	wire hit_force = addr == `SGS_OFS_FORCE;
	wire hit_remote = addr == `SGS_OFS_REMOTE;
	wire hit_status = addr == `SGS_OFS_STATUS;
	assign nxt_rdata = !rd ? '0 :
		hit_ctrl ? ctrl_ff :
		hit_force ? {4'h0, force_ff} :
		hit_remote ? {4'h0, remote_ff} :
		hit_status ? {ctrl_ff[`SGS_CTRL_FORCE_BIT], 4'h0, cfg.active_code} : '0;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff <= `SGS_RST_CTRL;
			force_ff <= `SGS_SEL_NONE;
			remote_ff <= `SGS_SEL_NONE;
			force_wr_ff <= 1'b0;
			remote_wr_ff <= 1'b0;
			rdata_ff <= '0;
		end
		else
		begin
			if (wr && hit_ctrl)
				ctrl_ff <= {1'b0, wdata[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB], 3'h0, wdata[`SGS_CTRL_FORCE_BIT]};
			if (wr && hit_force)
				force_ff <= wdata[`SGS_SEL_MSB:0];
			if (wr && hit_remote)
				remote_ff <= wdata[`SGS_SEL_MSB:0];
			force_wr_ff <= wr && hit_force && wdata[`SGS_SEL_MSB:0] != `SGS_SEL_NONE;
			remote_wr_ff <= wr && hit_remote && wdata[`SGS_SEL_MSB:0] != `SGS_SEL_NONE;
			rdata_ff <= nxt_rdata;
		end
	end
	assign rdata = rdata_ff;
	assign cfg.force_en = ctrl_ff[`SGS_CTRL_FORCE_BIT];
	assign cfg.used_cnt = {1'b0, ctrl_ff[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB]} + 4'h1;
	assign cfg.force_sel = force_ff;
	assign cfg.remote_sel = remote_ff;
	assign cfg.force_wr = force_wr_ff;
	assign cfg.remote_wr = remote_wr_ff;
endmodule // sgs_regs
`default_nettype wire

// ---- sgs_req_model.sv ----
// far-side model: internal logic and digital inputs driving the group requests
`timescale 1ns/1ns
`default_nettype none
module sgs_req_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] lvl,
	input wire logic [7:0] pls,
	output logic [7:0] req_pin
);
	// a pulse lasts one cycle on the pins, a level stands as long as lvl is held
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			req_pin <= 8'h00;
		else
			req_pin <= lvl | pls;
	end
endmodule // sgs_req_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench of the setting group selector
`timescale 1ns/1ns
`default_nettype none
`include "sgs_map.svh"
module testbench;
	logic clk;
	logic rst;
	logic [7:0] lvl;
	logic [7:0] pls;
	logic [7:0] req_pin;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] active_group;
	logic [2:0] active_code;
	logic [7:0] group_enabled;
	logic [7:0] group_load_default;
	logic req_refused;
	int err_count;
	int n_tests;
	int exp_g;
	int used;
	logic [7:0] m;

	sgs_req_model PEER (.clk(clk), .rst(rst), .lvl(lvl), .pls(pls), .req_pin(req_pin));
	sgs_selector DUT (.clk(clk), .rst(rst), .req_pin(req_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_group(active_group),
		.active_code(active_code), .group_enabled(group_enabled), .group_load_default(group_load_default),
		.req_refused(req_refused));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic chk_act(input int g);
		chk("active_group", 8'h01 << g, active_group);
		chk("active_code", 8'(g), {5'h00, active_code});
	endtask

	// lands just after the edge so every registered output has settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	task automatic pulse(input logic [7:0] mask);
		@(posedge clk);
		pls <= mask;
		@(posedge clk);
		pls <= 8'h00;
	endtask

	task automatic set_lvl(input logic [7:0] mask);
		@(posedge clk);
		lvl <= mask;
	endtask

	// the old group stands just after the write edge; the new one and the refusal pulse one edge later
	task automatic wr_req(input logic [3:0] a, input logic [7:0] d, input int g, input logic refused);
		wr(a, d);
		#1;
		chk_act(exp_g);
		cyc(1);
		chk_act(g);
		chk("req_refused", {7'h00, refused}, {7'h00, req_refused});
		exp_g = g;
	endtask

	function automatic int first(input logic [7:0] mask);
		for (int i = 0; i < 8; i++)
			if (mask[i])
				return i;
		return -1;
	endfunction

	function automatic logic [7:0] en_mask(input int u);
		return 8'((9'h001 << u) - 9'h001);
	endfunction

	task automatic print_verdict;
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		rst = 1'b1;
		lvl = 8'h00;
		pls = 8'h00;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		err_count = 0;
		n_tests = 0;
		exp_g = 0;
		void'($urandom(73));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_act(0);
		chk("group_enabled", 8'h01, group_enabled);
		for (int a = 0; a < 16; a += 2)
			rd_chk(4'(a), 8'h00);
		set_lvl(8'h04);
		cyc(6);
		chk_act(0);
		set_lvl(8'h00);
		cyc(3);
		wr(`SGS_OFS_CTRL, 8'h70);
		#1;
		chk("group_load_default", 8'h00, group_load_default);
		cyc(1);
		chk("group_enabled", 8'hff, group_enabled);
		chk("group_load_default", 8'hfe, group_load_default);
		cyc(1);
		chk("group_load_default", 8'h00, group_load_default);
		wr(`SGS_OFS_STATUS, 8'h85);
		rd_chk(`SGS_OFS_STATUS, 8'h00);
		set_lvl(8'h08);
		cyc(6);
		pulse(8'h30);
		cyc(6);
		chk_act(3);
		set_lvl(8'h80);
		cyc(6);
		chk_act(7);
		// a held group eight level lets a pulse win for one cycle, then selects itself again
		pulse(8'h20);
		cyc(3);
		chk_act(5);
		cyc(1);
		chk_act(7);
		set_lvl(8'h00);
		exp_g = 7;
		// odd passes hold levels, even passes send pulses; a level is dropped before used changes
		for (int it = 0; it < 40; it++)
		begin
			used = 1 + $urandom % 8;
			wr(`SGS_OFS_CTRL, 8'((used - 1) << 4));
			if (exp_g >= used)
				exp_g = 0;
			cyc(3);
			chk("group_enabled", en_mask(used), group_enabled);
			m = 8'($urandom);
			if (it % 2)
				set_lvl(m);
			else
				pulse(m);
			cyc(6);
			if (first(m & en_mask(used)) >= 0)
				exp_g = first(m & en_mask(used));
			chk_act(exp_g);
			set_lvl(8'h00);
			cyc(6);
			chk_act(exp_g);
		end
		wr(`SGS_OFS_CTRL, 8'h71);
		if (exp_g >= 8)
			exp_g = 0;
		cyc(3);
		rd_chk(`SGS_OFS_STATUS, 8'h80 | 8'(exp_g));
		pulse(8'h01);
		cyc(6);
		chk_act(exp_g);
		wr_req(`SGS_OFS_FORCE, 8'h03, 2, 1'b0);
		wr(`SGS_OFS_CTRL, 8'h31);
		cyc(3);
		wr_req(`SGS_OFS_FORCE, 8'h06, 2, 1'b1);
		set_lvl(8'h02);
		cyc(6);
		chk_act(2);
		wr_req(`SGS_OFS_REMOTE, 8'h04, 2, 1'b1);
		wr_req(`SGS_OFS_REMOTE, 8'h01, 0, 1'b0);
		wr_req(`SGS_OFS_FORCE, 8'h04, 3, 1'b0);
		wr(`SGS_OFS_CTRL, 8'h30);
		cyc(3);
		chk_act(1);
		exp_g = 1;
		set_lvl(8'h00);
		wr_req(`SGS_OFS_FORCE, 8'h03, 1, 1'b1);
		wr_req(`SGS_OFS_REMOTE, 8'h03, 1, 1'b1);
		wr(`SGS_OFS_CTRL, 8'h31);
		cyc(3);
		wr_req(`SGS_OFS_FORCE, 8'h03, 2, 1'b0);
		wr(`SGS_OFS_CTRL, 8'h30);
		cyc(6);
		chk_act(2);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
